// ---- rtl/gpio_data_config_port.sv ----
// Purpose: General purpose pin port with per-pin configuration and packed data registers
// Assumes: APB slave on clk; pads split into input, output and output enable
// Notes: Answer comes one cycle into the access phase; unmapped access raises pslverr
//
// What this block does
// R1 - Each pin: one data bit, 8-bit configuration
// R2 - Pin data bits packed into 8-bit ports
// R3 - Input pin: data bit reads pin level
// R4 - Output pin: written bit drives the pin
// R5 - Latch pin on read, hold written value
// R6 - All registers sit in runtime register map
// R7 - Reserved data bits: writes ignored, read zero
//
// The APB slave port is this design's own decision.

`timescale 1ns/10ps

module gpio_data_config_port
	import gpio_port_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_PINS-1:0] pinIn,
	output logic [NUM_PINS-1:0] pinOut,
	output logic [NUM_PINS-1:0] pinOe
);

	// ------------------------------------------------------------
	// Bus phase decode
	// ------------------------------------------------------------
	logic setupPhase;                  // First cycle of a transfer
	logic commit;                      // Edge at which the transfer completes
	logic aligned;                     // Word-aligned address
	logic [IDX_W-1:0] regIndex;        // Word index of the access
	logic [NUM_PINS-1:0] hitCfg;       // Configuration register selected per pin
	logic [NUM_PORTS-1:0] hitData;     // Data register selected per port
	logic anyHit;                      // Access lands on a mapped register

	// ------------------------------------------------------------
	// Per-pin state seen by the bus
	// ------------------------------------------------------------
	logic [CFG_W-1:0] cfg [NUM_PINS];  // Configuration of each pin
	logic [NUM_PINS-1:0] level;        // Synchronised pin levels
	logic [NUM_PINS-1:0] outLatch;     // Latched output values
	logic [NUM_PINS-1:0] dataBit;      // Data bit as software sees it
	logic [DATA_W-1:0] portVal [NUM_PORTS];
	logic [31:0] readVal;              // Value to capture for a read

	// ------------------------------------------------------------
	// Bus answer registers
	// ------------------------------------------------------------
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// Phase and address decode
	always_comb begin
		setupPhase = psel && !penable;
		commit = psel && penable && pready;
		aligned = (paddr[1:0] == 2'h0);
		regIndex = paddr[ADDR_W-1:2];
	end

	// Register map lookup, all within the runtime register block
	always_comb begin
		anyHit = 1'h0;
		for (int i = 0; i < NUM_PINS; i++) begin
			hitCfg[i] = aligned && (regIndex == PIN_CFG_IDX[i]);       // [R6]
			anyHit = anyHit || hitCfg[i];
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			hitData[p] = aligned && (regIndex == PORT_DATA_IDX[p]);    // [R6]
			anyHit = anyHit || hitData[p];
		end
	end

	// ------------------------------------------------------------
	// Pin cells
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			logic wrCfg;               // Configuration write strobe
			logic wrData;              // Data bit write strobe

			// Strobes fire only at the completing edge of a write
			always_comb begin
				wrCfg = commit && pwrite && hitCfg[gi];
				wrData = commit && pwrite && hitData[PIN_PORT[gi]];
			end

			// One data bit and one configuration register per pin [R1]
			gpio_pin_cell #(
				.CFG_RST(CFG_RESET)
			) u_cell (
				.clk(clk),
				.sys_rst(sys_rst),
				.ce(ce),
				.wrCfg(wrCfg),
				.wrData(wrData),
				.cfgIn(pwdata[CFG_W-1:0]),
				.dataIn(pwdata[PIN_BIT[gi]]),
				.pinIn(pinIn[gi]),
				.cfg(cfg[gi]),
				.level(level[gi]),
				.outLatch(outLatch[gi]),
				.pinOut(pinOut[gi]),
				.pinOe(pinOe[gi])
			);

			// Input reads the pin, output reads back its latch
			always_comb begin
				dataBit[gi] = cfg[gi][CFG_DIR_BIT] ? level[gi] : outLatch[gi];   // [R3]
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Data port assembly
	// ------------------------------------------------------------
	// Each pin owns one fixed bit of one port; unowned bits stay zero
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			portVal[p] = '0;                                            // [R7]
		end
		for (int i = 0; i < NUM_PINS; i++) begin
			portVal[PIN_PORT[i]][PIN_BIT[i]] = dataBit[i];              // [R2]
		end
	end

	// Read mux; unmapped reads return zero
	always_comb begin
		readVal = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (hitCfg[i]) begin
				readVal[CFG_W-1:0] = cfg[i];
			end
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (hitData[p]) begin
				readVal[DATA_W-1:0] = portVal[p];
			end
		end
	end

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// Read data is latched at setup and held through the access phase
	always_comb begin
		next_prdata = prdata;
		next_pready = 1'h0;
		next_pslverr = 1'h0;
		if (setupPhase && !pready) begin
			// Pin level captured at the moment of the read [R5]
			next_prdata = pwrite ? 32'h0000_0000 : readVal;
			next_pready = 1'h1;
			next_pslverr = !anyHit;
		end else if (psel && penable && !pready) begin
			// Access phase without a setup cycle seen: answer anyway
			next_pready = 1'h1;
			next_pslverr = !anyHit;
		end
	end

	// Answer registers, frozen while ce is low
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'h0;
			pslverr <= 1'h0;
		end else if (ce) begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_setup;
		psel && !penable && !pready && ce;
	endsequence

	sequence s_read_setup;
		s_setup and !pwrite;
	endsequence

	property p_answer_pulse;
		s_setup ##1 ce |=> !pready;
	endproperty

	a_setup_answer: assert property (s_setup |=> pready) // [R6]
		else $error("no answer one cycle after setup");
	a_answer_pulse: assert property (p_answer_pulse) // [R6]
		else $error("pready held longer than one cycle");
	a_unmapped_err: assert property (s_setup and !anyHit |=> pslverr) // [R6]
		else $error("unmapped access without pslverr");
	a_read_latch: assert property (s_read_setup |=> prdata == $past(readVal)) // [R5]
		else $error("read data not captured at setup");
	a_reserved_zero: assert property (s_read_setup and hitData[1] // [R7]
		|=> (prdata[DATA_W-1:0] & PORT_RSV_MASK[1]) == 8'h00)
		else $error("reserved data bit reads nonzero");
	a_cfg_write: assert property (ce && commit && pwrite && hitCfg[0] // [R1]
		|=> cfg[0] == $past(pwdata[CFG_W-1:0]))
		else $error("configuration write lost");
	a_port_pack: assert property (s_read_setup and hitData[0] // [R2]
		|=> prdata[DATA_W-1:0] == $past(dataBit[7:0]))
		else $error("port one packing wrong");

endmodule

// ---- include/gpio_port_pkg.sv ----
// Purpose: Shared constants for the general purpose pin data and configuration port
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Pin table maps each pin to its configuration index, data port and bit

package gpio_port_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_PINS = 11;      // Pins behind the two data ports
	localparam int NUM_PORTS = 2;      // Data registers held by this block
	localparam int CFG_W = 8;          // Configuration register width
	localparam int DATA_W = 8;         // Data register width
	localparam int ADDR_W = 10;        // APB byte address width
	localparam int IDX_W = 8;          // Register index width

	// ------------------------------------------------------------
	// Register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] REG_PORT1_PIN0_CONFIG = 8'h23;
	localparam logic [IDX_W-1:0] REG_PORT1_PIN1_CONFIG = 8'h24;
	localparam logic [IDX_W-1:0] REG_PORT1_PIN2_CONFIG = 8'h25;
	localparam logic [IDX_W-1:0] REG_PORT1_PIN3_CONFIG = 8'h26;
	localparam logic [IDX_W-1:0] REG_PORT1_PIN4_CONFIG = 8'h27;
	localparam logic [IDX_W-1:0] REG_PORT1_PIN5_CONFIG = 8'h29;
	localparam logic [IDX_W-1:0] REG_PORT1_PIN6_CONFIG = 8'h2A;
	localparam logic [IDX_W-1:0] REG_PORT1_PIN7_CONFIG = 8'h2B;
	localparam logic [IDX_W-1:0] REG_PORT2_PIN1_CONFIG = 8'h2C;
	localparam logic [IDX_W-1:0] REG_PORT2_PIN2_CONFIG = 8'h2D;
	localparam logic [IDX_W-1:0] REG_PORT2_PIN7_CONFIG = 8'h32;
	localparam logic [IDX_W-1:0] REG_PORT1_DATA = 8'h4B;
	localparam logic [IDX_W-1:0] REG_PORT2_DATA = 8'h4C;

	// ------------------------------------------------------------
	// Pin map: configuration index, data port, data bit
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] PIN_CFG_IDX [NUM_PINS] = '{
		REG_PORT1_PIN0_CONFIG, REG_PORT1_PIN1_CONFIG, REG_PORT1_PIN2_CONFIG,
		REG_PORT1_PIN3_CONFIG, REG_PORT1_PIN4_CONFIG, REG_PORT1_PIN5_CONFIG,
		REG_PORT1_PIN6_CONFIG, REG_PORT1_PIN7_CONFIG, REG_PORT2_PIN1_CONFIG,
		REG_PORT2_PIN2_CONFIG, REG_PORT2_PIN7_CONFIG};
	localparam logic [0:0] PIN_PORT [NUM_PINS] = '{
		1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
	localparam logic [2:0] PIN_BIT [NUM_PINS] = '{
		3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h7};
	localparam logic [IDX_W-1:0] PORT_DATA_IDX [NUM_PORTS] = '{REG_PORT1_DATA, REG_PORT2_DATA};
	localparam logic [DATA_W-1:0] PORT_RSV_MASK [NUM_PORTS] = '{8'h00, 8'h79};

	// ------------------------------------------------------------
	// Configuration fields and reset values
	// ------------------------------------------------------------
	localparam int CFG_DIR_BIT = 0;    // 1 = input, 0 = output
	localparam int CFG_OD_BIT = 7;     // 1 = open-drain output
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h01;
	localparam logic OUT_RESET = 1'h0;

endpackage

// ---- rtl/gpio_pin_cell.sv ----
// Purpose: One general purpose pin: configuration, output latch, input sync, pad drive
// Assumes: Writes arrive as one-cycle strobes on the system clock
// Notes: Pad signals leave straight from flip-flops

`timescale 1ns/10ps

module gpio_pin_cell
	import gpio_port_pkg::*;
#(
	parameter logic [CFG_W-1:0] CFG_RST = CFG_RESET
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic wrCfg,
	input wire logic wrData,
	input wire logic [CFG_W-1:0] cfgIn,
	input wire logic dataIn,
	input wire logic pinIn,
	output logic [CFG_W-1:0] cfg,
	output logic level,
	output logic outLatch,
	output logic pinOut,
	output logic pinOe
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic syncA;                       // First sync stage, read only by level
	logic [CFG_W-1:0] next_cfg;
	logic next_outLatch;
	logic next_pinOut;
	logic next_pinOe;

	// Next values for configuration, latch and pad
	always_comb begin
		next_cfg = wrCfg ? cfgIn : cfg;
		next_outLatch = wrData ? dataIn : outLatch;     // Held until next write [R5]
		// Output pin shows the latched value; open-drain only pulls low [R4]
		next_pinOut = next_cfg[CFG_OD_BIT] ? 1'h0 : next_outLatch;
		next_pinOe = !next_cfg[CFG_DIR_BIT] && (!next_cfg[CFG_OD_BIT] || !next_outLatch);
	end

	// Registers, frozen while ce is low
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg <= CFG_RST;
			outLatch <= OUT_RESET;
			pinOut <= 1'h0;
			pinOe <= 1'h0;
			syncA <= 1'h0;
			level <= 1'h0;
		end else if (ce) begin
			cfg <= next_cfg;
			outLatch <= next_outLatch;
			pinOut <= next_pinOut;
			pinOe <= next_pinOe;
			syncA <= pinIn;            // Two stages before the level is used [R3]
			level <= syncA;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_latch_write: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
		ce && wrData |=> outLatch == $past(dataIn))
		else $error("output latch missed a write");
	a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
		!wrData |=> outLatch == $past(outLatch))
		else $error("output latch changed without a write");
	a_sync_two: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
		$past(ce) && $past(ce, 2) && !$past(sys_rst) && !$past(sys_rst, 2)
		|-> level == $past(pinIn, 2))
		else $error("pin level not two cycles behind pin");
	a_out_drive: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
		ce && !next_cfg[CFG_DIR_BIT] && !next_cfg[CFG_OD_BIT]
		|=> pinOe && pinOut == outLatch)
		else $error("output pin not driven with latch");

endmodule

// ---- bench/gpio_data_config_port_test.sv ----
// Purpose: Self-checking bench for the pin data and configuration port
// Assumes: APB answer one cycle into access; input level seen two edges late
// Notes: Reset first, then table rows, output, input, reserved, freeze and second reset cases

`timescale 1ns/10ps

module gpio_data_config_port_test
	import gpio_port_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic sysRst = 1'b1; // Synchronous reset request
	logic ce = 1'b1; // Clock enable, driven low only in the freeze case
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [NUM_PINS-1:0] pinIn = '0;
	logic [NUM_PINS-1:0] pinOut;
	logic [NUM_PINS-1:0] pinOe;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0; // Timeout counter
	logic [31:0] rd;
	logic err;

	typedef struct {logic wr; logic [IDX_W-1:0] idx; logic [31:0] wd; logic [31:0] ex; logic er;} row_t;
	row_t rows [8] = '{
		'{1'b1, REG_PORT1_PIN0_CONFIG, 32'h00, 32'h0, 1'b0},
		'{1'b0, REG_PORT1_PIN0_CONFIG, 32'h0, 32'h00, 1'b0},
		'{1'b1, REG_PORT2_PIN7_CONFIG, 32'hFFFFFFA5, 32'h0, 1'b0},
		'{1'b0, REG_PORT2_PIN7_CONFIG, 32'h0, 32'hA5, 1'b0},
		'{1'b1, REG_PORT1_DATA, 32'h01, 32'h0, 1'b0},
		'{1'b0, REG_PORT1_DATA, 32'h0, 32'h01, 1'b0},
		'{1'b1, 8'h28, 32'hFF, 32'h0, 1'b1},
		'{1'b0, 8'h4D, 32'h0, 32'h0, 1'b1}};

	// ------------------------------------------------------------
	// Clock, design and timeout
	// ------------------------------------------------------------
	always #25 clk = ~clk;

	gpio_data_config_port i_dut (.clk(clk), .sys_rst(sysRst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

	// Cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk_data(input logic [31:0] ex, input logic [31:0] got);
		cmp_count++;
		if (got !== ex) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, ex);
		end
	endtask

	task automatic chk_pins(input logic [NUM_PINS-1:0] ex, input logic [NUM_PINS-1:0] got);
		cmp_count++;
		if (got !== ex) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, ex);
		end
	endtask

	// One APB transfer; holds the request until pready is seen
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// No local limit: pready or the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read and compare
	task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] ex);
		apb(1'b0, idx, 32'h0);
		chk_data(ex, rd);
	endtask

	// Lets pad flops settle before the caller samples them
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		sysRst <= 1'b0;
		// Reset: every pin an input, pads released
		#1;
		chk_pins('0, pinOe);
		for (int i = 0; i < NUM_PINS; i++) begin
			rdchk(PIN_CFG_IDX[i], {24'h0, CFG_RESET});
		end
		$display("test reset done");
		// Table rows
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].idx, rows[i].wd);
			if (!rows[i].wr) begin
				chk_data(rows[i].ex, rd);
			end
			chk_data({31'h0, rows[i].er}, {31'h0, err});
		end
		$display("test table done");
		// Output pin holds its latch and ignores its pad
		settle();
		chk_pins(11'h001, pinOut & 11'h001);
		chk_pins(11'h001, pinOe);
		@(posedge clk);
		pinIn <= 11'h5A5;
		settle();
		rdchk(REG_PORT1_DATA, 32'hA5);
		rdchk(REG_PORT2_DATA, 32'h82);
		apb(1'b1, REG_PORT1_DATA, 32'hFE);
		settle();
		chk_pins(11'h000, pinOut & 11'h001);
		rdchk(REG_PORT1_DATA, 32'hA4);
		$display("test pins done");
		// Port 2 all outputs; reserved bits stay clear
		apb(1'b1, REG_PORT2_PIN1_CONFIG, 32'h00);
		apb(1'b1, REG_PORT2_PIN2_CONFIG, 32'h00);
		apb(1'b1, REG_PORT2_PIN7_CONFIG, 32'h00);
		apb(1'b1, REG_PORT2_DATA, 32'hFF);
		settle();
		chk_pins(11'h701, pinOe);
		chk_pins(11'h700, pinOut & 11'h700);
		rdchk(REG_PORT2_DATA, 32'h86);
		$display("test reserved done");
		// Clock enable low: pin sampling frozen, old level still read once
		@(posedge clk);
		ce <= 1'b0;
		pinIn <= 11'h000;
		repeat (4) @(posedge clk);
		ce <= 1'b1;
		rdchk(REG_PORT1_DATA, 32'hA4);
		rdchk(REG_PORT1_DATA, 32'h00);
		$display("test freeze done");
		// Reset in mid-run
		@(posedge clk);
		sysRst <= 1'b1;
		@(posedge clk);
		sysRst <= 1'b0;
		#1;
		chk_pins('0, pinOe);
		chk_pins('0, pinOut);
		rdchk(REG_PORT1_PIN0_CONFIG, {24'h0, CFG_RESET});
		$display("test second reset done");
		end_of_test();
	end
endmodule
